// File: common/sgdec_pkg.sv
// Operation
// - Serial-B accesses are claimed and forwarded only while bit 31 and the serial-B monitor enable are both set.
// - The serial-B select codes 000..111 pick 3F8h, 2F8h, 220h, 228h, 238h, 2E8h, 338h and 3E8h eight-byte windows.
// - Serial-A accesses are claimed and forwarded only while bit 27 and the serial-A monitor enable are both set.
// - Serial-A select codes 100..111 pick the 238h, 2E8h, 338h and 3E8h eight-byte windows.
// - The generic chip select is asserted for an access in the generic range while bits 23 and 22 are set.
// - Generic-range accesses are claimed and forwarded while bit 22 and the generic monitor enable are set.
// - The generic base and mask decode runs only while bit 21 is set; each feature needs its own enable too.
// - The 4-bit generic mask covers address bits 3:0 and a 1 drops that bit from the compare.
// - Every address bit is compared on its own, so split mask patterns give split ranges.
// - The 16-bit generic base is compared with address bits 15:0 on every unmasked position.
package sgdec_pkg;

  localparam int SGDEC_PADDR_W = 8;
  localparam int SGDEC_IO_W    = 16;
  localparam int SGDEC_MASK_W  = 4;
  localparam int SGDEC_SER_LSB = 3;

  // Register byte offsets
  localparam logic [7:0] SGDEC_CTRL_OFS = 8'h64;
  localparam logic [7:0] SGDEC_AUX_OFS  = 8'h80;
  localparam logic [7:0] SGDEC_STAT_OFS = 8'h84;

  // Reset values
  localparam logic [31:0] SGDEC_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0]  SGDEC_AUX_RST  = 2'h0;
  localparam logic [4:0]  SGDEC_STAT_RST = 5'h00;

  // Control register fields
  localparam int SGDEC_B_FWD_BIT  = 31;
  localparam int SGDEC_B_SEL_LSB  = 28;
  localparam int SGDEC_A_FWD_BIT  = 27;
  localparam int SGDEC_A_SEL_LSB  = 24;
  localparam int SGDEC_G_CS_BIT   = 23;
  localparam int SGDEC_G_FWD_BIT  = 22;
  localparam int SGDEC_G_MON_BIT  = 21;
  localparam int SGDEC_RSVD_BIT   = 20;
  localparam int SGDEC_MASK_LSB   = 16;
  localparam int SGDEC_BASE_LSB   = 0;
  localparam logic [31:0] SGDEC_CTRL_WMASK = 32'hFFEF_FFFF;

  // Auxiliary register fields
  localparam int SGDEC_AUX_A_MON_BIT = 0;
  localparam int SGDEC_AUX_B_MON_BIT = 1;

  // Eight-byte serial windows indexed by select code
  localparam logic [15:0] SGDEC_SER_WIN [0:7] = '{
    16'h03F8, 16'h02F8, 16'h0220, 16'h0228,
    16'h0238, 16'h02E8, 16'h0338, 16'h03E8
  };

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } sgdec_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sgdec_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } sgdec_io_req_t;

  typedef struct packed {
    logic claim;
    logic serial_a;
    logic serial_b;
    logic generic;
    logic chip_sel;
  } sgdec_io_rsp_t;

endpackage : sgdec_pkg

// File: logic/sgdec_serial_match.sv
`timescale 1ns/1ps
module sgdec_serial_match
  import sgdec_pkg::*;
#(
  parameter int ADDR_W = SGDEC_IO_W
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [2:0]        sel,
  output wire logic              hit
);

  wire logic [15:0] win_base;

  assign win_base = SGDEC_SER_WIN[sel];
  // Whole eight-byte window: low three bits are don't-care
  assign hit = (addr[ADDR_W-1:SGDEC_SER_LSB]
                == win_base[ADDR_W-1:SGDEC_SER_LSB]);

endmodule : sgdec_serial_match

// File: logic/sgdec_generic_match.sv
`timescale 1ns/1ps
module sgdec_generic_match
  import sgdec_pkg::*;
#(
  parameter int ADDR_W = SGDEC_IO_W,
  parameter int MASK_W = SGDEC_MASK_W
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [ADDR_W-1:0] base,
  input  wire logic [MASK_W-1:0] mask,
  output wire logic              hit
);

  wire logic [ADDR_W-1:0] ignore;
  wire logic [ADDR_W-1:0] diff;

  assign ignore = {{(ADDR_W-MASK_W){1'b0}}, mask};
  // Bitwise compare, so split masks give split ranges
  assign diff   = (addr ^ base) & ~ignore;
  assign hit    = (diff == '0);

endmodule : sgdec_generic_match

// File: logic/sgdec_top.sv
`timescale 1ns/1ps
module sgdec_top
  import sgdec_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire sgdec_apb_req_t apb_req,
  output wire sgdec_apb_rsp_t apb_rsp,
  input  wire sgdec_io_req_t  io_req,
  output wire sgdec_io_rsp_t  io_rsp,
  output wire logic           generic_chip_select_n
);

  // Registers
  logic [31:0]    ctrl_reg;
  logic [31:0]    ctrl_next;
  logic [1:0]     aux_reg;
  logic [1:0]     aux_next;
  logic [4:0]     stat_reg;
  sgdec_apb_rsp_t apb_rsp_reg;
  sgdec_io_rsp_t  io_rsp_reg;
  sgdec_io_rsp_t  io_rsp_next;
  logic           cs_n_reg;

  // Control fields
  wire logic                  serial_b_forward_en;
  wire logic [2:0]            serial_b_range_sel;
  wire logic                  serial_a_forward_en;
  wire logic [2:0]            serial_a_range_sel;
  wire logic                  generic_chip_select_en;
  wire logic                  generic_forward_en;
  wire logic                  generic_monitor_en;
  wire logic [SGDEC_MASK_W-1:0] generic_range_mask;
  wire logic [SGDEC_IO_W-1:0]   generic_range_base;
  wire logic                  serial_a_monitor_en;
  wire logic                  serial_b_monitor_en;

  assign serial_b_forward_en    = ctrl_reg[SGDEC_B_FWD_BIT];
  assign serial_b_range_sel     = ctrl_reg[SGDEC_B_SEL_LSB +: 3];
  assign serial_a_forward_en    = ctrl_reg[SGDEC_A_FWD_BIT];
  assign serial_a_range_sel     = ctrl_reg[SGDEC_A_SEL_LSB +: 3];
  assign generic_chip_select_en = ctrl_reg[SGDEC_G_CS_BIT];
  assign generic_forward_en     = ctrl_reg[SGDEC_G_FWD_BIT];
  assign generic_monitor_en     = ctrl_reg[SGDEC_G_MON_BIT];
  assign generic_range_mask     = ctrl_reg[SGDEC_MASK_LSB +: SGDEC_MASK_W];
  assign generic_range_base     = ctrl_reg[SGDEC_BASE_LSB +: SGDEC_IO_W];
  assign serial_a_monitor_en    = aux_reg[SGDEC_AUX_A_MON_BIT];
  assign serial_b_monitor_en    = aux_reg[SGDEC_AUX_B_MON_BIT];

  // ---------------- APB slave ----------------
  wire logic        apb_access;
  wire logic        apb_commit;
  wire logic        sel_ctrl;
  wire logic        sel_aux;
  wire logic        sel_stat;
  wire logic        sel_none;
  wire logic [31:0] byte_mask;
  wire logic [31:0] rd_data;
  wire logic        wr_ctrl;
  wire logic        wr_aux;

  // One wait state: pready rises on the second access cycle
  assign apb_access = apb_req.psel & apb_req.penable;
  assign apb_commit = apb_access & apb_rsp_reg.pready;

  assign sel_ctrl = (apb_req.paddr == SGDEC_CTRL_OFS);
  assign sel_aux  = (apb_req.paddr == SGDEC_AUX_OFS);
  assign sel_stat = (apb_req.paddr == SGDEC_STAT_OFS);
  assign sel_none = ~(sel_ctrl | sel_aux | sel_stat);

  assign byte_mask = {{8{apb_req.pstrb[3]}}, {8{apb_req.pstrb[2]}},
                      {8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

  assign wr_ctrl = apb_commit & apb_req.pwrite & sel_ctrl;
  assign wr_aux  = apb_commit & apb_req.pwrite & sel_aux;

  // Reserved bit never stored, so it always reads zero
  assign ctrl_next = wr_ctrl ?
    (((ctrl_reg & ~byte_mask) | (apb_req.pwdata & byte_mask))
     & SGDEC_CTRL_WMASK) : ctrl_reg;

  assign aux_next = (wr_aux & apb_req.pstrb[0]) ?
                    apb_req.pwdata[1:0] : aux_reg;

  assign rd_data = sel_ctrl ? ctrl_reg :
                   sel_aux  ? {30'h0000_0000, aux_reg} :
                   sel_stat ? {27'h000_0000, stat_reg} :
                   32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= SGDEC_CTRL_RST;
      aux_reg  <= SGDEC_AUX_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      aux_reg  <= aux_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      apb_rsp_reg <= '0;
    end else if (apb_access & ~apb_rsp_reg.pready) begin
      apb_rsp_reg.pready  <= 1'b1;
      apb_rsp_reg.pslverr <= sel_none;
      apb_rsp_reg.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      apb_rsp_reg <= '0;
    end
  end

  assign apb_rsp = apb_rsp_reg;

  // ---------------- I/O decode ----------------
  wire logic serial_a_match;
  wire logic serial_b_match;
  wire logic generic_match;
  wire logic serial_a_claim;
  wire logic serial_b_claim;
  wire logic generic_hit;
  wire logic generic_claim;
  wire logic generic_cs;

  sgdec_serial_match #(
    .ADDR_W (SGDEC_IO_W)
  ) u_serial_b (
    .addr (io_req.addr),
    .sel  (serial_b_range_sel),
    .hit  (serial_b_match)
  );

  sgdec_serial_match #(
    .ADDR_W (SGDEC_IO_W)
  ) u_serial_a (
    .addr (io_req.addr),
    .sel  (serial_a_range_sel),
    .hit  (serial_a_match)
  );

  sgdec_generic_match #(
    .ADDR_W (SGDEC_IO_W),
    .MASK_W (SGDEC_MASK_W)
  ) u_generic (
    .addr (io_req.addr),
    .base (generic_range_base),
    .mask (generic_range_mask),
    .hit  (generic_match)
  );

  assign serial_b_claim = serial_b_match & serial_b_forward_en
                          & serial_b_monitor_en;
  assign serial_a_claim = serial_a_match & serial_a_forward_en
                          & serial_a_monitor_en;
  assign generic_hit    = generic_match & generic_monitor_en;
  assign generic_claim  = generic_hit & generic_forward_en;
  assign generic_cs     = generic_claim & generic_chip_select_en;

  always_comb begin
    io_rsp_next          = '0;
    io_rsp_next.serial_a = serial_a_claim;
    io_rsp_next.serial_b = serial_b_claim;
    io_rsp_next.generic  = generic_claim;
    io_rsp_next.chip_sel = generic_cs;
    io_rsp_next.claim    = serial_a_claim | serial_b_claim
                           | generic_claim;
  end

  // Results are one-cycle pulses a cycle after the access strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      io_rsp_reg <= '0;
      cs_n_reg   <= 1'b1;
      stat_reg   <= SGDEC_STAT_RST;
    end else if (io_req.valid) begin
      io_rsp_reg <= io_rsp_next;
      cs_n_reg   <= ~io_rsp_next.chip_sel;
      stat_reg   <= io_rsp_next;
    end else begin
      io_rsp_reg <= '0;
      cs_n_reg   <= 1'b1;
    end
  end

  assign io_rsp                = io_rsp_reg;
  assign generic_chip_select_n = cs_n_reg;

  // ---------------- Assertions ----------------
  serial_b_claim_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && serial_b_match && ctrl_reg[31] && aux_reg[1])
    |=> (io_rsp.serial_b && io_rsp.claim))
    else $error("serial B access not claimed");

  serial_b_off_a: assert property (
    @(posedge clk) disable iff (srst)
    (!ctrl_reg[31] || !aux_reg[1]) |=> !io_rsp.serial_b)
    else $error("serial B claimed while disabled");

  serial_b_win_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[31] && aux_reg[1]
     && ctrl_reg[30:28] == 3'h1 && io_req.addr[15:3] == 13'h005F)
    |=> io_rsp.serial_b)
    else $error("serial B code 001 missed 2F8h window");

  serial_a_claim_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[27] && aux_reg[0]) |=>
    (io_rsp.serial_a == $past(serial_a_match)))
    else $error("serial A claim mismatch");

  serial_a_high_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[27] && aux_reg[0]
     && ctrl_reg[26:24] == 3'h7 && io_req.addr[15:3] == 13'h007D)
    |=> io_rsp.serial_a)
    else $error("serial A code 111 missed 3E8h window");

  serial_a_low_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[27] && aux_reg[0]
     && ctrl_reg[26:24] == 3'h0 && io_req.addr[15:3] == 13'h007F)
    |=> io_rsp.serial_a ##1 (!io_rsp.serial_a || $past(io_req.valid)))
    else $error("serial A code 000 missed 3F8h window");

  generic_cs_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && generic_match && ctrl_reg[23:21] == 3'h7)
    |=> (!generic_chip_select_n && io_rsp.chip_sel))
    else $error("generic chip select not asserted");

  generic_claim_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && generic_match && ctrl_reg[22] && ctrl_reg[21])
    |=> io_rsp.generic)
    else $error("generic access not claimed");

  generic_gate_a: assert property (
    @(posedge clk) disable iff (srst)
    !ctrl_reg[21] |=> (!io_rsp.generic && generic_chip_select_n))
    else $error("generic decode active while disabled");

  split_mask_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[22:21] == 2'h3 && ctrl_reg[19:16] == 4'h9
     && io_req.addr[15:4] == ctrl_reg[15:4]
     && io_req.addr[2:1] == ctrl_reg[2:1]) |=> io_rsp.generic)
    else $error("split mask range missed");

  base_miss_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && io_req.addr[15:4] != ctrl_reg[15:4])
    |=> !io_rsp.generic)
    else $error("generic hit outside base");

  no_hit_a: assert property (
    @(posedge clk) disable iff (srst)
    (!serial_a_claim && !serial_b_claim && !generic_claim)
    |=> !io_rsp.claim)
    else $error("claim without an enabled hit");

  rsvd_zero_a: assert property (
    @(posedge clk) disable iff (srst)
    apb_rsp.pready |-> !apb_rsp.prdata[20] ##1 !apb_rsp.pready)
    else $error("reserved bit read as one or pready held");

  serial_b_mid_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[31] && aux_reg[1]
     && ctrl_reg[30:28] == 3'h4 && io_req.addr[15:3] == 13'h0047)
    |=> io_rsp.serial_b)
    else $error("serial B code 100 missed 238h window");

  serial_a_mid_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[27] && aux_reg[0]
     && ctrl_reg[26:24] == 3'h2 && io_req.addr[15:3] == 13'h0044)
    |=> io_rsp.serial_a)
    else $error("serial A code 010 missed 220h window");

  serial_a_off_a: assert property (
    @(posedge clk) disable iff (srst)
    (!ctrl_reg[27] || !aux_reg[0]) |=> !io_rsp.serial_a)
    else $error("serial A claimed while disabled");

  generic_off_a: assert property (
    @(posedge clk) disable iff (srst)
    !ctrl_reg[22] |=> (!io_rsp.generic && !io_rsp.chip_sel))
    else $error("generic claimed while forward disabled");

  cs_gate_a: assert property (
    @(posedge clk) disable iff (srst)
    !ctrl_reg[23] |=> (generic_chip_select_n && !io_rsp.chip_sel))
    else $error("generic chip select while disabled");

  mask_bit0_a: assert property (
    @(posedge clk) disable iff (srst)
    (io_req.valid && ctrl_reg[22:21] == 2'h3 && ctrl_reg[16]
     && io_req.addr[15:1] == ctrl_reg[15:1]) |=> io_rsp.generic)
    else $error("masked address bit 0 still compared");

  idle_quiet_a: assert property (
    @(posedge clk) disable iff (srst)
    !io_req.valid |=> (!io_rsp.claim && generic_chip_select_n))
    else $error("claim or chip select without an access");

endmodule : sgdec_top

// File: verification/sgdec_io_master.sv
`timescale 1ns/1ps
module sgdec_io_master
  import sgdec_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          go,
  input  wire logic [15:0]   go_addr,
  output sgdec_io_req_t      io_req
);
  // One-cycle I/O strobe; between strobes the address flips to its complement every cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      io_req <= '0;
    end else begin
      io_req.valid <= go;
      io_req.addr  <= go ? go_addr : ~io_req.addr;
    end
  end
endmodule : sgdec_io_master

// File: verification/sgdec_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module sgdec_top_test
  import sgdec_pkg::*;
;
  logic           clk = 0;
  logic           srst = 1;
  sgdec_apb_req_t apb_req = '0;
  sgdec_apb_rsp_t apb_rsp;
  sgdec_io_req_t  io_req;
  sgdec_io_rsp_t  io_rsp;
  logic           generic_chip_select_n;
  logic           go = 0;
  logic [15:0]    go_addr = 16'h0000;
  logic [31:0]    seed = 32'h0000_004B;
  logic [31:0]    ctrl_s = 32'h0;
  logic [1:0]     aux_s = 2'h0;
  logic [31:0]    rd;
  logic           er;
  int             num_errors = 0;
  int             total_checks = 0;
  localparam logic [15:0] win [8] = '{16'h03F8, 16'h02F8, 16'h0220,
    16'h0228, 16'h0238, 16'h02E8, 16'h0338, 16'h03E8};

  always #4 clk = ~clk;

  sgdec_top u_sgdec_top (.clk(clk), .srst(srst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .io_req(io_req), .io_rsp(io_rsp),
    .generic_chip_select_n(generic_chip_select_n));
  sgdec_io_master u_sgdec_io_master (.clk(clk), .srst(srst), .go(go),
    .go_addr(go_addr), .io_req(io_req));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [4:0] exp_rsp(logic [31:0] c, logic [1:0] x,
                                         logic [15:0] a);
    logic sa, sb, g;
    sa = c[27] & x[0] & (a[15:3] == win[c[26:24]][15:3]);
    sb = c[31] & x[1] & (a[15:3] == win[c[30:28]][15:3]);
    g  = c[21] & c[22] & (((a ^ c[15:0]) & ~{12'h0, c[19:16]}) == 16'h0);
    return {sa | sb | g, sa, sb, g, g & c[23]};
  endfunction : exp_rsp

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    apb_req.psel    <= 1'b1;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    apb_req.pstrb   <= 4'hF;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic set(input logic [31:0] c, input logic [1:0] x);
    apb(1'b1, SGDEC_CTRL_OFS, c);
    apb(1'b1, SGDEC_AUX_OFS, {30'h0, x});
    ctrl_s = c & 32'hFFEF_FFFF;
    aux_s  = x;
  endtask : set

  task automatic probe(input logic [15:0] a);
    logic [4:0] e;
    e = exp_rsp(ctrl_s, aux_s, a);
    @(posedge clk);
    go      <= 1'b1;
    go_addr <= a;
    @(posedge clk);
    go      <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(io_rsp, e)
    `CHK(generic_chip_select_n, ~e[0])
  endtask : probe

  task automatic summarize();
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    // About twelve times the expected run of some 1600 cycles
    #160_000;
    num_errors++;
    summarize();
  end

  initial begin
    logic [15:0] a;
    logic [31:0] r;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, SGDEC_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, SGDEC_CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, SGDEC_CTRL_OFS, 32'h0);
    `CHK(rd, 32'hFFEF_FFFF)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(er, 1'b1)
    for (int k = 0; k < 8; k++) begin
      set({1'b1, 3'(k), 1'b1, 3'(7 - k), 24'h0}, 2'h3);
      r = xs();
      probe(win[k] | {13'h0, r[2:0]});
      probe(win[7 - k] | {13'h0, r[5:3]});
      probe(win[k] + 16'h0008);
    end
    // Split range: mask 1001 around base 0x0340
    set(32'h00E9_0340, 2'h0);
    for (int i = 0; i < 16; i++) probe(16'h0340 ^ 16'(i));
    for (int i = 0; i < 240; i++) begin
      if (i % 6 == 0) set(xs(), 2'(xs()));
      r = xs();
      case (r[1:0])
        2'd0: a = win[ctrl_s[26:24]] | {13'h0, r[4:2]};
        2'd1: a = win[ctrl_s[30:28]] | {13'h0, r[4:2]};
        2'd2: a = ctrl_s[15:0] ^ {12'h0, r[5:2]};
        default: a = r[31:16];
      endcase
      probe(a);
      if (i % 10 == 0) begin
        apb(1'b0, SGDEC_STAT_OFS, 32'h0);
        `CHK(rd[4:0], exp_rsp(ctrl_s, aux_s, a))
      end
    end
    summarize();
  end
endmodule : sgdec_top_test
